// file: bench/barcode_field_padder_tb_top.sv
/*
 Self-checking bench for the barcode field padder: register port, input
 stream and a host sink model. Assumes the port contract of bfp_top.
*/
`timescale 1ns/1ps
module barcode_field_padder_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic in_valid = 1'b0;
    logic in_ready;
    logic [7:0] in_data = 8'h00;
    logic in_last = 1'b0;
    logic in_sel = 1'b0;
    logic out_valid;
    logic out_ready;
    logic [7:0] out_data;
    logic out_last;
    logic stall = 1'b0;
    logic gaps = 1'b0;
    int error_cnt = 0;
    int cmp_count = 0;
    int fields_sent = 0;
    logic [8:0] exp_q[$];
    logic [8:0] mon_e;
    logic [7:0] code[$];
    logic cfg_fixed, cfg_right;
    logic [5:0] cfg_len;
    logic [6:0] cfg_fill;

    always #5 clk = ~clk;

    bfp_top uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data), .in_last(in_last), .in_sel(in_sel),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .out_last(out_last));

    bfp_host_sink sink (.clk(clk), .rst_n(arst_n), .stall(stall), .out_valid(out_valid),
        .out_data(out_data), .out_last(out_last), .out_ready(out_ready));

    task automatic conclude();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic fail(input string msg);
        error_cnt++;
        $display("Error at %0t ns: %s", $time, msg);
    endtask : fail

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        cmp_count++;
        if (reg_rdata !== exp) fail($sformatf("read %h gave %h", a, reg_rdata));
    endtask : reg_read

    task automatic configure(input logic f, input logic r, input int len, input int fl);
        cfg_fixed = f;
        cfg_right = r;
        cfg_len = 6'(len);
        cfg_fill = 7'(fl);
        reg_write(bfp_pkg::A_CTRL,
                  (32'(r) << bfp_pkg::POS_RIGHT) | (32'(f) << bfp_pkg::POS_FIXED));
        reg_write(bfp_pkg::A_LEN, 32'(len));
        reg_write(bfp_pkg::A_FILL, 32'(fl));
        repeat (3) @(posedge clk);
    endtask : configure

    // Expected field worked out from mode, length and justification
    task automatic send_field(input int n, input logic sel);
        int pad;
        int w;
        code.delete();
        for (int i = 0; i < n; i++) code.push_back(8'h30 + 8'($urandom % 78));
        pad = (cfg_fixed && sel && cfg_len > n) ? cfg_len - n : 0;
        fields_sent++;
        for (int i = 0; i < pad && !cfg_right; i++) begin
            exp_q.push_back({1'b0, 1'b0, cfg_fill});
        end
        for (int i = 0; i < n; i++) begin
            exp_q.push_back({(i == n - 1 && (pad == 0 || !cfg_right)), code[i]});
        end
        for (int i = 0; i < pad && cfg_right; i++) begin
            exp_q.push_back({(i == pad - 1), 1'b0, cfg_fill});
        end
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            in_valid <= 1'b1;
            in_data <= code[i];
            in_last <= (i == n - 1);
            in_sel <= sel;
            w = 0;
            do begin
                @(posedge clk);
                w++;
            end while (!in_ready && w < 200);
            if (!in_ready) fail("input never accepted");
            if (gaps && $urandom % 4 == 0) begin
                in_valid <= 1'b0;
                @(posedge clk);
            end
        end
        in_valid <= 1'b0;
        in_last <= 1'b0;
    endtask : send_field

    task automatic drain();
        int w;
        w = 0;
        while (exp_q.size() > 0 && w < 2000) begin
            @(posedge clk);
            w++;
        end
        if (exp_q.size() > 0) fail("output field incomplete");
    endtask : drain

    task automatic run_case(input logic f, input logic r, input int len, input int fl,
                            input int n, input logic sel);
        configure(f, r, len, fl);
        send_field(n, sel);
        drain();
    endtask : run_case

    // Each accepted output character is matched against the oldest note
    always @(posedge clk) begin
        if (arst_n && out_valid === 1'b1 && out_ready) begin
            cmp_count++;
            if (exp_q.size() == 0) begin
                fail("unexpected output character");
            end else begin
                mon_e = exp_q.pop_front();
                if ({out_last, out_data} !== mon_e) begin
                    fail($sformatf("out %b %h", out_last, out_data));
                end
            end
        end
    end

    initial begin
        #200_000;
        fail("watchdog expired");
        conclude();
    end

    initial begin
        void'($urandom(1));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        reg_read(bfp_pkg::A_CTRL, 32'h0000_0000);
        reg_read(bfp_pkg::A_LEN, 32'h0000_0000);
        reg_read(bfp_pkg::A_FILL, 32'h0000_0020);
        reg_read(bfp_pkg::A_STAT, 32'h0000_0000);
        reg_read(4'h2, 32'h0000_0000);
        reg_write(bfp_pkg::A_LEN, 32'h0000_0030);
        reg_read(bfp_pkg::A_LEN, 32'h0000_0030);
        reg_write(bfp_pkg::A_LEN, 32'h0000_0031);
        reg_read(bfp_pkg::A_LEN, 32'h0000_0030);
        reg_write(bfp_pkg::A_FILL, 32'h0000_007E);
        reg_read(bfp_pkg::A_FILL, 32'h0000_007E);
        reg_write(bfp_pkg::A_FILL, 32'h0000_007F);
        reg_read(bfp_pkg::A_FILL, 32'h0000_007E);
        $display("Test registers done");
        run_case(1'b0, 1'b1, 10, 'h2A, 3, 1'b1);
        run_case(1'b0, 1'b0, 2, 'h2A, 9, 1'b1);
        run_case(1'b1, 1'b1, 5, 'h2E, 2, 1'b1);
        run_case(1'b1, 1'b0, 5, 'h2E, 2, 1'b1);
        run_case(1'b1, 1'b1, 3, 'h20, 6, 1'b1);
        run_case(1'b1, 1'b0, 3, 'h20, 6, 1'b1);
        run_case(1'b1, 1'b0, 4, 'h20, 4, 1'b1);
        run_case(1'b1, 1'b0, 48, 'h00, 1, 1'b1);
        run_case(1'b1, 1'b1, 48, 'h7E, 1, 1'b1);
        run_case(1'b1, 1'b0, 0, 'h2A, 3, 1'b1);
        run_case(1'b1, 1'b0, 5, 'h2A, 2, 1'b0);
        run_case(1'b1, 1'b1, 5, 'h2A, 2, 1'b0);
        $display("Test directed fields done");
        stall = 1'b1;
        gaps = 1'b1;
        for (int k = 0; k < 12; k++) begin
            configure($urandom % 2, $urandom % 2, $urandom % 49, $urandom % 127);
            for (int j = 0; j < 4; j++) begin
                send_field(1 + $urandom % 56, $urandom % 4 != 0);
            end
            drain();
        end
        $display("Test random fields done");
        // Reading status first also lets the sink's last count settle
        reg_read(bfp_pkg::A_STAT, 32'h0000_0000);
        cmp_count++;
        if (sink.field_cnt != fields_sent) fail("end marker count wrong");
        $display("Test field ends done");
        conclude();
    end
endmodule : barcode_field_padder_tb_top

// file: bench/bfp_host_sink.sv
/*
 Host message assembler model: takes formatted characters from the padder.
 Assumes the padder's out_* handshake on clk and an active-low reset.
*/
`timescale 1ns/1ps
module bfp_host_sink (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic out_valid,
    input wire logic [bfp_pkg::CHAR_W-1:0] out_data,
    input wire logic out_last,
    output logic out_ready
);
    int field_cnt;

    // A real assembler may drop ready at any cycle, so stalls are random
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ready <= 1'b0;
            field_cnt <= 0;
        end else begin
            out_ready <= stall ? ($urandom % 3 != 0) : 1'b1;
            if (out_valid && out_ready && out_last) begin
                field_cnt <= field_cnt + 1;
            end
        end
    end
endmodule : bfp_host_sink

// file: logic/bfp_link_if.sv
/*
 Carrier between the padder core, its register file and its character store.
 Assumes all three share clk; the core and register file also share the synchronised reset.
*/
`timescale 1ns/1ps
interface bfp_link_if;
    logic fixed;
    logic right;
    logic [bfp_pkg::LEN_W-1:0] len;
    logic [bfp_pkg::FILL_W-1:0] fill;
    logic busy;
    logic [bfp_pkg::LEN_W-1:0] cnt;
    logic wr_en;
    logic [bfp_pkg::LEN_W-1:0] wr_addr;
    logic [bfp_pkg::CHAR_W-1:0] wr_data;
    logic [bfp_pkg::LEN_W-1:0] rd_addr;
    logic [bfp_pkg::CHAR_W-1:0] rd_data;

    modport regs (output fixed, right, len, fill, input busy, cnt);
    modport core (input fixed, right, len, fill, rd_data,
                  output busy, cnt, wr_en, wr_addr, wr_data, rd_addr);
    modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : bfp_link_if

// file: logic/bfp_pkg.sv
/*
 Constants, register map and state encoding for the barcode field padder.
 Assumes a single 100 MHz clock and a plain strobe register port.
*/
// Notes on behaviour
// R1 - Variable mode passes codes at natural length
// R2 - Fixed mode never truncates longer codes
// R3 - Short codes padded up to field length
// R4 - Left justification puts fills before code
// R5 - Right justification puts fills after code
// R6 - Length, fill, justification matter only when fixed
// R7 - Field length accepts 0 through 48
// R8 - Fill character limited to 0x00..0x7E
// R9 - Only selected barcode fields are reshaped
// R10 - Valid/ready per character, last marks field end
package bfp_pkg;
    localparam int CHAR_W = 8;
    localparam int LEN_W = 6;
    localparam int FILL_W = 7;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int BUF_DEPTH = 48;

    localparam logic [ADDR_W-1:0] A_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] A_LEN = 4'h4;
    localparam logic [ADDR_W-1:0] A_FILL = 4'h8;
    localparam logic [ADDR_W-1:0] A_STAT = 4'hC;

    localparam int POS_FIXED = 0;
    localparam int POS_RIGHT = 1;

    localparam logic [DATA_W-1:0] LEN_MAX = 32'h0000_0030;
    localparam logic [DATA_W-1:0] FILL_MAX = 32'h0000_007E;

    localparam logic RST_FIXED = 1'b0;
    localparam logic RST_RIGHT = 1'b0;
    localparam logic [LEN_W-1:0] RST_LEN = 6'h00;
    localparam logic [FILL_W-1:0] RST_FILL = 7'h20;

    typedef enum logic [1:0] {
        BFP_RUN,
        BFP_FILL_PRE,
        BFP_DRAIN,
        BFP_FILL_POST
    } bfp_state_t;
endpackage : bfp_pkg

// file: logic/bfp_regs.sv
/*
 Register file: mode, field length, fill character and a status word.
 Assumes one-cycle write and read strobes that never coincide.
*/
`timescale 1ns/1ps
module bfp_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [bfp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [bfp_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [bfp_pkg::DATA_W-1:0] reg_rdata,
    bfp_link_if.regs lk
);
    typedef struct packed {
        logic fixed;
        logic right;
        logic [bfp_pkg::LEN_W-1:0] len;
        logic [bfp_pkg::FILL_W-1:0] fill;
        logic [bfp_pkg::DATA_W-1:0] rdata;
    } bfp_reg_t;

    bfp_reg_t cur;
    bfp_reg_t next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.rdata = '0;
        if (reg_wr) begin
            case (reg_addr)
                bfp_pkg::A_CTRL: begin
                    next_cur.fixed = reg_wdata[bfp_pkg::POS_FIXED];
                    next_cur.right = reg_wdata[bfp_pkg::POS_RIGHT];
                end
                bfp_pkg::A_LEN: begin
                    // Out-of-range lengths are dropped, the old value stays [R7]
                    if (reg_wdata <= bfp_pkg::LEN_MAX) begin
                        next_cur.len = reg_wdata[bfp_pkg::LEN_W-1:0];
                    end
                end
                bfp_pkg::A_FILL: begin
                    if (reg_wdata <= bfp_pkg::FILL_MAX) begin // [R8]
                        next_cur.fill = reg_wdata[bfp_pkg::FILL_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                bfp_pkg::A_CTRL: next_cur.rdata = {30'h0, cur.right, cur.fixed};
                bfp_pkg::A_LEN: next_cur.rdata = {26'h0, cur.len};
                bfp_pkg::A_FILL: next_cur.rdata = {25'h0, cur.fill};
                bfp_pkg::A_STAT: next_cur.rdata = {25'h0, lk.busy, lk.cnt};
                default: next_cur.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= {bfp_pkg::RST_FIXED, bfp_pkg::RST_RIGHT, bfp_pkg::RST_LEN,
                    bfp_pkg::RST_FILL, 32'h0000_0000};
        end else begin
            cur <= next_cur;
        end
    end

    assign reg_rdata = cur.rdata;
    assign lk.fixed = cur.fixed;
    assign lk.right = cur.right;
    assign lk.len = cur.len;
    assign lk.fill = cur.fill;

    // An accepted length must land, a refused one must leave the old value
    property p_len_range;
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == bfp_pkg::A_LEN)
            |=> (($past(reg_wdata) <= bfp_pkg::LEN_MAX)
                    ? (lk.len == $past(reg_wdata[bfp_pkg::LEN_W-1:0]))
                    : $stable(lk.len))
                && ({26'h0, lk.len} <= bfp_pkg::LEN_MAX);
    endproperty
    a_len_range: assert property (p_len_range) else $error("length write mishandled"); // [R7]

    property p_fill_range;
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == bfp_pkg::A_FILL)
            |=> (($past(reg_wdata) <= bfp_pkg::FILL_MAX)
                    ? (lk.fill == $past(reg_wdata[bfp_pkg::FILL_W-1:0]))
                    : $stable(lk.fill))
                && ({25'h0, lk.fill} <= bfp_pkg::FILL_MAX);
    endproperty
    a_fill_range: assert property (p_fill_range) else $error("fill write mishandled"); // [R8]
endmodule : bfp_regs

// file: logic/bfp_store.sv
/*
 Character store holding the head of a left-justified code until its length is known.
 Assumes the core never writes beyond the configured field length.
*/
`timescale 1ns/1ps
module bfp_store #(
    parameter int DEPTH = bfp_pkg::BUF_DEPTH
) (
    input wire logic clk,
    bfp_link_if.mem lk
);
    logic [bfp_pkg::CHAR_W-1:0] mem [DEPTH];

    // Not reset: contents are only read after being written in the same field
    always_ff @(posedge clk) begin
        if (lk.wr_en) begin
            mem[lk.wr_addr] <= lk.wr_data;
        end
    end

    assign lk.rd_data = mem[lk.rd_addr];
endmodule : bfp_store

// file: logic/bfp_top.sv
/*
 Barcode field padder: reshapes the barcode field of outgoing messages to a
 fixed length with a fill character, or passes it unchanged.
 Assumes both character streams run on clk; in_sel and in_last come with
 each character from the decoder side.
*/
`timescale 1ns/1ps
module bfp_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [bfp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [bfp_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [bfp_pkg::DATA_W-1:0] reg_rdata,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [bfp_pkg::CHAR_W-1:0] in_data,
    input wire logic in_last,
    input wire logic in_sel,
    output logic out_valid,
    input wire logic out_ready,
    output logic [bfp_pkg::CHAR_W-1:0] out_data,
    output logic out_last
);
    typedef struct packed {
        bfp_pkg::bfp_state_t st;
        logic fld;
        logic c_fixed;
        logic c_right;
        logic [bfp_pkg::LEN_W-1:0] c_len;
        logic [bfp_pkg::FILL_W-1:0] c_fill;
        logic [bfp_pkg::LEN_W-1:0] cnt;
        logic [bfp_pkg::LEN_W-1:0] pad;
        logic [bfp_pkg::LEN_W-1:0] ridx;
        logic end_last;
        logic o_v;
        logic [bfp_pkg::CHAR_W-1:0] o_d;
        logic o_l;
    } bfp_core_t;

    bfp_core_t cur;
    bfp_core_t next_cur;
    logic [1:0] rst_sync;
    logic rst_n;
    logic take;
    logic shaped;
    logic collect;
    logic [bfp_pkg::LEN_W:0] cnt_inc;
    logic [bfp_pkg::LEN_W:0] ridx_inc;
    logic [bfp_pkg::LEN_W:0] len_x;

    bfp_link_if lk ();

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    bfp_regs u_regs (
        .clk(clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .lk(lk.regs)
    );

    bfp_store #(.DEPTH(bfp_pkg::BUF_DEPTH)) u_store (
        .clk(clk),
        .lk(lk.mem)
    );

    assign cnt_inc = {1'b0, cur.cnt} + 7'h01;
    assign ridx_inc = {1'b0, cur.ridx} + 7'h01;
    assign len_x = {1'b0, cur.c_len};
    assign take = !cur.o_v || out_ready; // [R10]
    assign shaped = in_sel || cur.fld;
    // Only the head of a left-justified field is held back; anything longer streams [R2]
    assign collect = shaped && cur.c_fixed && !cur.c_right && (cur.cnt < cur.c_len);

    always_comb begin
        next_cur = cur;
        in_ready = 1'b0;
        lk.wr_en = 1'b0;
        lk.wr_addr = cur.cnt;
        lk.wr_data = in_data;
        lk.rd_addr = cur.ridx;
        if (take) begin
            next_cur.o_v = 1'b0;
        end
        // Settings are frozen for the whole field so a mid-field write cannot split it
        if (!cur.fld) begin
            next_cur.c_fixed = lk.fixed;
            next_cur.c_right = lk.right;
            next_cur.c_len = lk.len;
            next_cur.c_fill = lk.fill;
        end
        case (cur.st)
            bfp_pkg::BFP_RUN: begin
                if (collect) begin
                    in_ready = 1'b1;
                    if (in_valid) begin
                        lk.wr_en = 1'b1;
                        next_cur.fld = 1'b1;
                        next_cur.cnt = cnt_inc[bfp_pkg::LEN_W-1:0];
                        next_cur.ridx = '0;
                        if (in_last) begin
                            next_cur.end_last = 1'b1;
                            if (cnt_inc < len_x) begin
                                next_cur.pad = cur.c_len - cnt_inc[bfp_pkg::LEN_W-1:0]; // [R3]
                                next_cur.st = bfp_pkg::BFP_FILL_PRE; // [R4]
                            end else begin
                                next_cur.st = bfp_pkg::BFP_DRAIN;
                            end
                        end else if (cnt_inc == len_x) begin
                            next_cur.end_last = 1'b0;
                            next_cur.st = bfp_pkg::BFP_DRAIN; // [R2]
                        end
                    end
                end else begin
                    in_ready = take;
                    if (in_valid && take) begin
                        // Pass unchanged: other fields, variable mode, overlong codes [R1] [R9]
                        next_cur.o_v = 1'b1;
                        next_cur.o_d = in_data;
                        next_cur.o_l = in_last;
                        if (shaped) begin
                            if (in_last) begin
                                next_cur.fld = 1'b0;
                                next_cur.cnt = '0;
                            end else begin
                                next_cur.fld = 1'b1;
                                if (cur.c_fixed && cur.c_right && cur.cnt < cur.c_len) begin
                                    next_cur.cnt = cnt_inc[bfp_pkg::LEN_W-1:0];
                                end
                            end
                            // Settings act only in fixed mode [R6]
                            if (cur.c_fixed && cur.c_right && in_last && cnt_inc < len_x) begin
                                next_cur.o_l = 1'b0;
                                next_cur.fld = 1'b1;
                                next_cur.pad = cur.c_len - cnt_inc[bfp_pkg::LEN_W-1:0]; // [R3]
                                next_cur.st = bfp_pkg::BFP_FILL_POST; // [R5]
                            end
                        end
                    end
                end
            end
            bfp_pkg::BFP_FILL_PRE: begin
                if (take) begin
                    next_cur.o_v = 1'b1;
                    next_cur.o_d = {1'b0, cur.c_fill}; // [R4]
                    next_cur.o_l = 1'b0;
                    next_cur.pad = cur.pad - 6'h01;
                    if (cur.pad == 6'h01) begin
                        next_cur.st = bfp_pkg::BFP_DRAIN;
                    end
                end
            end
            bfp_pkg::BFP_DRAIN: begin
                if (take) begin
                    next_cur.o_v = 1'b1;
                    next_cur.o_d = lk.rd_data;
                    next_cur.o_l = cur.end_last && (ridx_inc == {1'b0, cur.cnt});
                    next_cur.ridx = ridx_inc[bfp_pkg::LEN_W-1:0];
                    if (ridx_inc == {1'b0, cur.cnt}) begin
                        next_cur.st = bfp_pkg::BFP_RUN;
                        if (cur.end_last) begin
                            next_cur.cnt = '0;
                            next_cur.fld = 1'b0;
                        end
                    end
                end
            end
            bfp_pkg::BFP_FILL_POST: begin
                if (take) begin
                    next_cur.o_v = 1'b1;
                    next_cur.o_d = {1'b0, cur.c_fill}; // [R5]
                    next_cur.o_l = (cur.pad == 6'h01); // [R10]
                    next_cur.pad = cur.pad - 6'h01;
                    if (cur.pad == 6'h01) begin
                        next_cur.st = bfp_pkg::BFP_RUN;
                        next_cur.cnt = '0;
                        next_cur.fld = 1'b0;
                    end
                end
            end
            default: begin
                next_cur.st = bfp_pkg::BFP_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign out_valid = cur.o_v;
    assign out_data = cur.o_d;
    assign out_last = cur.o_l;
    assign lk.busy = cur.fld;
    assign lk.cnt = cur.cnt;

    logic acc;
    assign acc = in_valid && in_ready;

    property p_var_pass;
        @(posedge clk) disable iff (!rst_n)
        (acc && !cur.c_fixed) |=> out_valid && out_data == $past(in_data)
            && out_last == $past(in_last);
    endproperty
    a_var_pass: assert property (p_var_pass) else $error("variable mode altered data"); // [R1]

    property p_long_pass;
        @(posedge clk) disable iff (!rst_n)
        (acc && cur.c_fixed && shaped && cur.cnt >= cur.c_len && cur.st == bfp_pkg::BFP_RUN)
            |=> out_valid && out_data == $past(in_data);
    endproperty
    a_long_pass: assert property (p_long_pass) else $error("long code not passed whole"); // [R2]

    property p_pad_count;
        @(posedge clk) disable iff (!rst_n)
        (acc && cur.c_fixed && cur.c_right && shaped && in_last && cnt_inc < len_x)
            |=> cur.st == bfp_pkg::BFP_FILL_POST
                && {1'b0, cur.pad} == $past(len_x) - $past(cnt_inc);
    endproperty
    a_pad_count: assert property (p_pad_count) else $error("wrong pad count"); // [R3]

    sequence s_pre_end;
        cur.st == bfp_pkg::BFP_FILL_PRE && take && cur.pad == 6'h01;
    endsequence
    sequence s_drain_first;
        cur.st == bfp_pkg::BFP_DRAIN && cur.ridx == 6'h00 && out_valid
            && out_data == {1'b0, cur.c_fill};
    endsequence
    property p_left_order;
        @(posedge clk) disable iff (!rst_n)
        s_pre_end |=> s_drain_first;
    endproperty
    a_left_order: assert property (p_left_order) else $error("fills not before code"); // [R4]

    property p_right_fill;
        @(posedge clk) disable iff (!rst_n)
        (cur.st == bfp_pkg::BFP_FILL_POST && take)
            |=> out_valid && out_data == {1'b0, $past(cur.c_fill)}
                && out_last == ($past(cur.pad) == 6'h01);
    endproperty
    a_right_fill: assert property (p_right_fill) else $error("trailing fill wrong"); // [R5]

    property p_cfg_frozen;
        @(posedge clk) disable iff (!rst_n)
        cur.fld ##1 cur.fld |-> $stable(cur.c_len) && $stable(cur.c_fill)
            && $stable(cur.c_right) && $stable(cur.c_fixed);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen) else $error("settings moved mid-field"); // [R6]

    property p_other_pass;
        @(posedge clk) disable iff (!rst_n)
        (acc && !in_sel && !cur.fld) |=> out_valid && out_data == $past(in_data)
            && out_last == $past(in_last) && !cur.fld;
    endproperty
    a_other_pass: assert property (p_other_pass) else $error("other field altered"); // [R9]

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        (out_valid && !out_ready) |=> out_valid && $stable(out_data) && $stable(out_last);
    endproperty
    a_hold: assert property (p_hold) else $error("output dropped under stall"); // [R10]

    // Leading fills never carry the end marker; the stored code still follows
    property p_pre_fill;
        @(posedge clk) disable iff (!rst_n)
        (cur.st == bfp_pkg::BFP_FILL_PRE && take)
            |=> out_valid && out_data == {1'b0, $past(cur.c_fill)} && !out_last;
    endproperty
    a_pre_fill: assert property (p_pre_fill) else $error("leading fill wrong"); // [R4]

    property p_pre_count;
        @(posedge clk) disable iff (!rst_n)
        (acc && collect && in_last && cnt_inc < len_x)
            |=> cur.st == bfp_pkg::BFP_FILL_PRE
                && {1'b0, cur.pad} == $past(len_x) - $past(cnt_inc);
    endproperty
    a_pre_count: assert property (p_pre_count) else $error("wrong leading pad count"); // [R3]

    // A character taken during fill or drain would be lost or misplaced
    property p_busy_refuse;
        @(posedge clk) disable iff (!rst_n)
        cur.st != bfp_pkg::BFP_RUN |-> !in_ready;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("input taken in fill"); // [R10]

    property p_drain_end;
        @(posedge clk) disable iff (!rst_n)
        (cur.st == bfp_pkg::BFP_DRAIN && take && ridx_inc == {1'b0, cur.cnt} && cur.end_last)
            |=> out_last && cur.st == bfp_pkg::BFP_RUN && !cur.fld;
    endproperty
    a_drain_end: assert property (p_drain_end) else $error("stored code end lost"); // [R10]
endmodule : bfp_top
